/* ssc_pkg.sv */
// package: constants and types for the sysref sync and chip mode control block
package ssc_pkg;

   // ----------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------------
   localparam logic [9:0]  IDX_CAPTURE_CTRL   = 10'h120;
   localparam logic [9:0]  IDX_SYSREF_COUNT   = 10'h12A;
   localparam logic [9:0]  IDX_SYNC_MODE      = 10'h1FF;
   localparam logic [9:0]  IDX_APP_MODE       = 10'h200;
   localparam logic [9:0]  IDX_DECIM_RATIO    = 10'h201;
   localparam int          ADDR_W             = 12;
   localparam int          IDX_LSB            = 2;

   // ----------------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------------
   localparam int          CAP_CLEAR_BIT      = 6;
   localparam int          CAP_MODE_LSB       = 1;
   localparam logic [1:0]  CAP_MODE_DISABLED  = 2'h0;
   localparam int          SYNC_MODE_BIT      = 0;
   localparam logic        SYNC_DIVIDER_RESET = 1'h0;
   localparam logic        SYNC_TIMESTAMP     = 1'h1;
   localparam int          Q_IGNORE_BIT       = 5;
   localparam int          APP_RSVD_LSB       = 6;
   localparam logic [7:0]  COUNT_RESET        = 8'h00;
   localparam logic [7:0]  COUNT_MAX          = 8'hFF;
   localparam logic [3:0]  FIELD4_RESET       = 4'h0;

   // ----------------------------------------------------------------------
   // application mode and decimation encodings
   // ----------------------------------------------------------------------
   localparam logic [3:0]  APP_FULL_BW        = 4'h0;
   localparam logic [3:0]  APP_ONE_DDC        = 4'h1;
   localparam logic [3:0]  APP_TWO_DDC        = 4'h2;
   localparam logic [3:0]  APP_FOUR_DDC       = 4'h3;
   localparam logic [3:0]  DECIM_BY_1         = 4'h0;
   localparam logic [3:0]  DECIM_BY_2         = 4'h1;
   localparam logic [3:0]  DDC_NONE           = 4'h0;
   localparam logic [3:0]  DDC_0              = 4'h1;
   localparam logic [3:0]  DDC_01             = 4'h3;
   localparam logic [3:0]  DDC_ALL            = 4'hF;

   localparam int          SAMPLE_W           = 14;
   localparam int          DIV_W              = 2;
   localparam logic [1:0]  DIV_ZERO           = 2'h0;
   localparam logic [1:0]  DIV_ONE            = 2'h1;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } ssc_apb_req_s;

   typedef struct packed {
      logic [SAMPLE_W-1:0] sampI;
      logic [SAMPLE_W-1:0] sampQ;
   } ssc_sample_s;

   typedef struct packed {
      logic [SAMPLE_W-1:0] sampI;
      logic [SAMPLE_W-1:0] sampQ;
      logic                qValid;
      logic                stamp;
   } ssc_out_word_s;

endpackage : ssc_pkg

/* ssc_regs.sv */
// module: sysref event tally, sync mode and chip mode registers behind apb
// Function
// - eight-bit read-only tally of captured sysref events
// - writing capture control bit 6 clears tally
// - tally wraps from 255 to zero
// - sync mode 0: sysref resets all dividers
// - divider phase change drops the serial link
// - timestamp mode leaves dividers untouched
// - timestamp mode: link and monitor undisturbed
// - timestamp mode marks sample with control bit
// - sync bit resets 0; bits 7:1 read zero
// - bit 5 set outputs only real samples
// - application mode selects which downconverters run
// - decimation 0000 bypasses, 0001 decimates by two
`timescale 1ns/1ps
module ssc_regs
   import ssc_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          rst,
   input  wire ssc_apb_req_s  apbReq,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          sysrefPin,
   input  wire ssc_sample_s   sampleIn,
   output ssc_out_word_s      outWord,
   output logic               dividerReset,
   output logic [DIV_W-1:0]   dividerPhase,
   output logic               linkDown,
   output logic [3:0]         ddcEnable,
   output logic               ddcBypass,
   output logic [3:0]         decimRatio
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [2:0]        syncSh;
      logic              sysLvl;
      logic [1:0]        capMode;
      logic [7:0]        tally;
      logic              syncMode;
      logic [1:0]        appRsvd;
      logic              qIgnore;
      logic [3:0]        appMode;
      logic [3:0]        decim;
      logic [DIV_W-1:0]  divPh;
      logic              divRst;
      logic              linkDn;
      logic [31:0]       rdata;
      logic              ready;
      logic              slvErr;
      ssc_out_word_s     word;
      logic [3:0]        ddcEn;
      logic              bypass;
   } ssc_state_s;

   ssc_state_s state_q;
   ssc_state_s state_d;

   // ----------------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------------
   function automatic logic isMapped(input logic [ADDR_W-1:0] a);
      logic [9:0] idx;
      idx = a[ADDR_W-1:IDX_LSB];
      return (a[IDX_LSB-1:0] == 2'h0) &&
             (idx == IDX_CAPTURE_CTRL || idx == IDX_SYSREF_COUNT ||
              idx == IDX_SYNC_MODE || idx == IDX_APP_MODE || idx == IDX_DECIM_RATIO);
   endfunction : isMapped

   function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
      return (a[IDX_LSB-1:0] == 2'h0) && (a[ADDR_W-1:IDX_LSB] == idx);
   endfunction : hits

   function automatic logic [3:0] ddcDecode(input logic [3:0] mode);
      case (mode)
         APP_FULL_BW:  ddcDecode = DDC_NONE;
         APP_ONE_DDC:  ddcDecode = DDC_0;
         APP_TWO_DDC:  ddcDecode = DDC_01;
         APP_FOUR_DDC: ddcDecode = DDC_ALL;
         default:      ddcDecode = DDC_NONE;
      endcase
   endfunction : ddcDecode

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   logic       stable;
   logic       capEvent;
   logic       access;
   logic       doWrite;
   logic [7:0] wb;

   always_comb begin
      state_d = state_q;
      wb      = apbReq.pwdata[7:0];

      // sysref pin: three flops, level accepted when last two agree
      state_d.syncSh = {state_q.syncSh[1:0], sysrefPin};
      stable         = (state_q.syncSh[2] == state_q.syncSh[1]);
      if (stable) begin
         state_d.sysLvl = state_q.syncSh[1];
      end
      capEvent = stable && state_q.syncSh[1] && !state_q.sysLvl &&
                 (state_q.capMode != CAP_MODE_DISABLED);

      // tally advances and wraps naturally past the maximum
      if (capEvent) begin
         state_d.tally = state_q.tally + 8'h01;
      end

      // free-running divider; sysref realigns it in divider-reset mode
      state_d.divPh  = state_q.divPh + DIV_ONE;
      state_d.divRst = 1'b0;
      state_d.linkDn = 1'b0;
      if (capEvent && state_q.syncMode == SYNC_DIVIDER_RESET) begin
         state_d.divPh  = DIV_ZERO;
         state_d.divRst = 1'b1;
         state_d.linkDn = (state_q.divPh != DIV_ZERO);
      end

      // output word; stamp only in timestamp mode, link untouched there
      state_d.word.sampI  = sampleIn.sampI;
      state_d.word.sampQ  = state_q.qIgnore ? '0 : sampleIn.sampQ;
      state_d.word.qValid = !state_q.qIgnore;
      state_d.word.stamp  = capEvent && (state_q.syncMode == SYNC_TIMESTAMP);
      state_d.ddcEn       = ddcDecode(state_q.appMode);

      // apb: one wait state, write and read take effect with pready
      access          = apbReq.psel && apbReq.penable;
      doWrite         = access && state_q.ready && apbReq.pwrite && isMapped(apbReq.paddr);
      state_d.ready   = access && !state_q.ready;
      state_d.slvErr  = access && !state_q.ready && !isMapped(apbReq.paddr);
      state_d.rdata   = '0;
      if (access && !state_q.ready && !apbReq.pwrite) begin
         if (hits(apbReq.paddr, IDX_CAPTURE_CTRL)) begin
            state_d.rdata[CAP_MODE_LSB+:2] = state_q.capMode;
         end
         if (hits(apbReq.paddr, IDX_SYSREF_COUNT)) begin
            state_d.rdata[7:0] = state_q.tally;
         end
         if (hits(apbReq.paddr, IDX_SYNC_MODE)) begin
            state_d.rdata[SYNC_MODE_BIT] = state_q.syncMode;
         end
         if (hits(apbReq.paddr, IDX_APP_MODE)) begin
            state_d.rdata[7:0] = {state_q.appRsvd, state_q.qIgnore, 1'b0, state_q.appMode};
         end
         if (hits(apbReq.paddr, IDX_DECIM_RATIO)) begin
            state_d.rdata[7:0] = {4'h0, state_q.decim};
         end
      end

      // writes touch only writable fields; tally kept, reserved app mode bits 7:6 written
      if (doWrite) begin
         if (hits(apbReq.paddr, IDX_CAPTURE_CTRL)) begin
            state_d.capMode = wb[CAP_MODE_LSB+:2];
            if (wb[CAP_CLEAR_BIT]) begin
               state_d.tally = COUNT_RESET;
               if (capEvent) begin
                  state_d.tally = 8'h01;
               end
            end
         end
         if (hits(apbReq.paddr, IDX_SYNC_MODE)) begin
            state_d.syncMode = wb[SYNC_MODE_BIT];
         end
         if (hits(apbReq.paddr, IDX_APP_MODE)) begin
            state_d.appRsvd = wb[APP_RSVD_LSB+:2];
            state_d.qIgnore = wb[Q_IGNORE_BIT];
            state_d.appMode = wb[3:0];
         end
         if (hits(apbReq.paddr, IDX_DECIM_RATIO)) begin
            state_d.decim = wb[3:0];
         end
      end
      state_d.bypass = (state_d.decim == DECIM_BY_1);
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q          <= '0;
         state_q.syncMode <= SYNC_DIVIDER_RESET;
         state_q.appMode  <= APP_FULL_BW;
         state_q.decim    <= DECIM_BY_1;
         state_q.capMode  <= CAP_MODE_DISABLED;
         state_q.tally    <= COUNT_RESET;
         state_q.word.qValid <= 1'b1;
         state_q.bypass      <= 1'b1;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign prdata       = state_q.rdata;
   assign pready       = state_q.ready;
   assign pslverr      = state_q.slvErr;
   assign outWord      = state_q.word;
   assign dividerReset = state_q.divRst;
   assign dividerPhase = state_q.divPh;
   assign linkDown     = state_q.linkDn;
   assign ddcEnable    = state_q.ddcEn;
   assign ddcBypass    = state_q.bypass;
   assign decimRatio   = state_q.decim;

endmodule : ssc_regs

/* ssc_regs_assertions.sv */
// checker: port-level properties of the sysref sync and chip mode registers
`timescale 1ns/1ps
module ssc_regs_assertions
   import ssc_pkg::*;
(
   input wire logic          clock,
   input wire logic          rst,
   input wire ssc_apb_req_s  apbReq,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire ssc_out_word_s outWord,
   input wire logic          dividerReset,
   input wire logic [1:0]    dividerPhase,
   input wire logic          linkDown,
   input wire logic [3:0]    ddcEnable,
   input wire logic          ddcBypass,
   input wire logic [3:0]    decimRatio
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------------
   // apb timing
   // ----------------------------------------------------------------------
   sequence sSetupAccess;
      apbReq.psel && !apbReq.penable ##1 apbReq.psel && apbReq.penable;
   endsequence
   AST_ONE_WAIT: assert property (sSetupAccess |=> pready ##1 !pready)
      else $error("pready not in second access cycle");
   AST_ERR_PULSE: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("pslverr without pready or with data");
   AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   // ----------------------------------------------------------------------
   // sync and mode outputs
   // ----------------------------------------------------------------------
   AST_DIV_ALIGN: assert property (dividerReset |-> dividerPhase == DIV_ZERO)
      else $error("dividers not aligned on sysref");
   AST_LINK_DROP: assert property (linkDown |-> dividerReset && $past(dividerPhase) != 2'h0)
      else $error("link drop without phase change");
   AST_STAMP_QUIET: assert property (outWord.stamp |-> !dividerReset && !linkDown)
      else $error("timestamp event disturbed dividers or link");
   AST_Q_IGNORE: assert property (!outWord.qValid |-> outWord.sampQ == 14'h0)
      else $error("q component not suppressed");
   AST_BYPASS: assert property (ddcBypass == (decimRatio == 4'h0))
      else $error("bypass does not follow decimation field");
   AST_DDC_CODE: assert property (ddcEnable inside {4'h0, 4'h1, 4'h3, 4'hF})
      else $error("illegal downconverter enable pattern");
endmodule : ssc_regs_assertions

/* ssc_regs_test.sv */
// testbench: apb register and sysref checks for the sync and chip mode block
`timescale 1ns/1ps
module ssc_regs_test;
   import ssc_pkg::*;
   logic clock, rst, sysrefPin, pready, pslverr, dividerReset, linkDown, ddcBypass;
   logic [31:0] prdata, rdat;
   logic        rerr;
   logic [1:0]  dividerPhase;
   logic [3:0]  ddcEnable, decimRatio;
   ssc_apb_req_s  req;
   ssc_sample_s   samp;
   ssc_out_word_s outWord;
   int fails, samples_checked, nDiv, nStamp, cyc;
   logic [3:0] ddcExp [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
   ssc_regs i_dut (.clock(clock), .rst(rst), .apbReq(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sysrefPin(sysrefPin), .sampleIn(samp), .outWord(outWord),
      .dividerReset(dividerReset), .dividerPhase(dividerPhase), .linkDown(linkDown),
      .ddcEnable(ddcEnable), .ddcBypass(ddcBypass), .decimRatio(decimRatio));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc++;
      if (dividerReset === 1'b1) nDiv++;
      if (outWord.stamp === 1'b1) nStamp++;
      if (cyc == 12000) begin
         fails++;
         test_done();
      end
   end
   // ----------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clock);
      req <= '{1'b1, 1'b0, w, {idx, 2'b00}, wd};
      @(posedge clock);
      req.penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      if (n >= 50) fails++;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rdat, exp);
   endtask : rdchk
   task automatic events(input int k);
      repeat (k) begin
         sysrefPin <= 1'b1;
         repeat (4) @(posedge clock);
         sysrefPin <= 1'b0;
         repeat (5) @(posedge clock);
      end
   endtask : events
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      req = '0;
      sysrefPin = 1'b0;
      samp = '{14'h1234, 14'h2345};
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rdchk(IDX_SYSREF_COUNT, 32'h0);
      rdchk(IDX_SYNC_MODE, 32'h0);
      rdchk(IDX_APP_MODE, 32'h0);
      rdchk(IDX_DECIM_RATIO, 32'h0);
      apb(1'b1, IDX_SYNC_MODE, 32'hFF);
      rdchk(IDX_SYNC_MODE, 32'h01);
      apb(1'b1, IDX_APP_MODE, 32'hFF);
      rdchk(IDX_APP_MODE, 32'hEF);
      apb(1'b1, IDX_DECIM_RATIO, 32'hFF);
      rdchk(IDX_DECIM_RATIO, 32'h0F);
      apb(1'b1, IDX_SYSREF_COUNT, 32'hFF);
      rdchk(IDX_SYSREF_COUNT, 32'h0);
      apb(1'b0, 10'h001, 32'h0);
      chk({rdat[30:0], rerr}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, IDX_APP_MODE, 32'h20 | i);
         repeat (2) @(posedge clock);
         chk(ddcEnable, ddcExp[i]);
         chk({outWord.qValid, outWord.sampQ, outWord.sampI}, {15'h0, samp.sampI});
      end
      apb(1'b1, IDX_APP_MODE, 32'h00);
      repeat (2) @(posedge clock);
      chk({outWord.qValid, outWord.sampQ}, {1'b1, samp.sampQ});
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, IDX_DECIM_RATIO, i);
         repeat (2) @(posedge clock);
         chk({ddcBypass, decimRatio}, {~i[0], 3'h0, i[0]});
      end
      apb(1'b1, IDX_SYNC_MODE, 32'h0);
      events(2);
      chk(nDiv, 0);
      apb(1'b1, IDX_CAPTURE_CTRL, 32'h02);
      events(3);
      chk({nDiv, nStamp}, {32'd3, 32'd0});
      apb(1'b1, IDX_SYNC_MODE, 32'h1);
      events(2);
      chk({nDiv, nStamp}, {32'd3, 32'd2});
      apb(1'b1, IDX_CAPTURE_CTRL, 32'h0);
      rdchk(IDX_SYSREF_COUNT, 32'd5);
      apb(1'b1, IDX_CAPTURE_CTRL, 32'h42);
      rdchk(IDX_SYSREF_COUNT, 32'h0);
      events(255);
      apb(1'b1, IDX_CAPTURE_CTRL, 32'h0);
      rdchk(IDX_SYSREF_COUNT, 32'hFF);
      apb(1'b1, IDX_CAPTURE_CTRL, 32'h02);
      events(1);
      apb(1'b1, IDX_CAPTURE_CTRL, 32'h0);
      rdchk(IDX_SYSREF_COUNT, 32'h0);
      test_done();
   end
endmodule : ssc_regs_test
bind ssc_regs ssc_regs_assertions i_chk (.clock(clock), .rst(rst), .apbReq(apbReq),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .outWord(outWord),
   .dividerReset(dividerReset), .dividerPhase(dividerPhase), .linkDown(linkDown),
   .ddcEnable(ddcEnable), .ddcBypass(ddcBypass), .decimRatio(decimRatio));
